// ### pkg/sirq_pkg.sv
// Package for the serial port interrupt request block: map, fields, types.
`default_nettype none
package sirq_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] status_offset  = 8'h00;
  localparam logic [7:0] control_offset = 8'h04;
  localparam logic [7:0] data_offset    = 8'h08;
  localparam logic [7:0] rxdata_offset  = 8'h0c;
  localparam logic [7:0] evt_offset     = 8'h10;
  localparam logic [7:0] mask_offset    = 8'h14;
  // Status register bit positions.
  localparam int st_rx_full_bit  = 0;
  localparam int st_tx_empty_bit = 1;
  localparam int st_tx_done_bit  = 2;
  localparam int st_overrun_bit  = 3;
  localparam int st_framing_bit  = 4;
  localparam int st_parity_bit   = 5;
  // Control register bit positions.
  localparam int ct_rx_irq_bit   = 0;
  localparam int ct_tx_irq_bit   = 1;
  localparam int ct_te_irq_bit   = 2;
  localparam int ct_err_irq_bit  = 3;
  // Reset values.
  localparam logic [5:0] status_reset  = 6'h06;
  localparam logic [3:0] control_reset = 4'h0;
  localparam logic [7:0] txbuf_reset   = 8'hff;
  localparam logic [7:0] rxbuf_reset   = 8'h00;
  localparam logic [5:0] mask_reset    = 6'h00;
  // Cycles the transmit shifter is busy with one byte.
  localparam logic [7:0] tx_shift_cycles = 8'h0a;
  typedef struct packed {
    logic parity;
    logic framing;
    logic overrun;
    logic tx_done;
    logic tx_empty;
    logic rx_full;
  } sirq_status_type;
  typedef struct packed {
    logic rx_error_request;
    logic tx_end_request;
    logic tx_empty_request;
    logic rx_full_request;
  } sirq_req_type;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       overrun;
    logic       framing;
    logic       parity;
  } sirq_rx_type;
  typedef enum logic [0:0] {
    tx_idle = 1'b0,
    tx_busy = 1'b1
  } sirq_tx_state_type;
endpackage
`default_nettype wire

// ### rtl/sirq_txshift.sv
// Transmit shifter timing model: holds a byte for a fixed number of cycles.
`default_nettype none
module sirq_txshift (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  output var  logic       busy_q,
  output var  logic [7:0] shift_q
);
  logic [7:0] count_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_q  <= 1'b0;
      count_q <= 8'h00;
      shift_q <= 8'h00;
    end else if (load) begin
      busy_q  <= 1'b1;
      count_q <= sirq_pkg::tx_shift_cycles;
      shift_q <= load_data;
    end else if (busy_q) begin
      count_q <= count_q - 8'h01;
      shift_q <= {1'b1, shift_q[7:1]};
      if (count_q == 8'h01) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/sirq_top.sv
// Serial port status flags, interrupt requests and AHB-Lite register slave.
`default_nettype none
module sirq_top (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output var  logic [31:0]          hrdata,
  output var  logic                 hreadyout,
  output var  logic                 hresp,
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_overrun,
  input  wire logic                 rx_framing,
  input  wire logic                 rx_parity,
  output var  logic                 tx_busy,
  output var  logic [7:0]           tx_data,
  output var  sirq_pkg::sirq_req_type requests,
  output var  logic                 irq
);
  // Receive event inputs come from the line side, so they are synchronised.
  sirq_pkg::sirq_rx_type rx_meta_q;
  sirq_pkg::sirq_rx_type rx_sync_q;
  sirq_pkg::sirq_rx_type rx_prev_q;
  logic                  rx_event;

  sirq_pkg::sirq_status_type status_q;
  logic [3:0]                control_q;
  logic [7:0]                txbuf_q;
  logic [7:0]                rxbuf_q;
  logic [5:0]                evt_q;
  logic [5:0]                evt_set;
  logic [5:0]                mask_q;
  logic [5:0]                status_prev_q;

  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic        txbuf_write;
  logic        status_write;
  logic        evt_write;
  logic        rxbuf_read;
  logic        shift_load;
  logic        shift_busy;
  logic [7:0]  shift_data;
  logic [31:0] rdata_d;

  function automatic logic is_access(input logic [7:0] a,
                                     input logic [7:0] off);
    is_access = (a == off);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_meta_q <= '0;
      rx_sync_q <= '0;
      rx_prev_q <= '0;
    end else begin
      rx_meta_q <= {rx_valid, rx_data, rx_overrun, rx_framing, rx_parity};
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  // The valid line is treated as a level that rises once per byte.
  assign rx_event = rx_sync_q.valid & ~rx_prev_q.valid;

  // AHB-Lite address phase capture; the slave never inserts wait states.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      rd_pend_q <= hsel & htrans[1] & ~hwrite;
      addr_q    <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign txbuf_write  = wr_pend_q & is_access(addr_q,
                                              sirq_pkg::data_offset);
  assign status_write = wr_pend_q & is_access(addr_q,
                                              sirq_pkg::status_offset);
  assign evt_write    = wr_pend_q & is_access(addr_q,
                                              sirq_pkg::evt_offset);
  assign rxbuf_read   = hready & hsel & htrans[1] & ~hwrite
                        & is_access(haddr[7:0], sirq_pkg::rxdata_offset);

  // Shifter takes the buffered byte once it is idle and a byte waits.
  assign shift_load = ~shift_busy & ~status_q.tx_empty;

  sirq_txshift u_txshift (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .load      (shift_load),
    .load_data (txbuf_q),
    .busy_q    (shift_busy),
    .shift_q   (shift_data)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      txbuf_q <= sirq_pkg::txbuf_reset;
    end else if (txbuf_write) begin
      txbuf_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxbuf_q <= sirq_pkg::rxbuf_reset;
    end else if (rx_event) begin
      rxbuf_q <= rx_sync_q.data;
    end
  end

  // Transmit flags: a buffer write clears empty and complete; the move
  // into the shifter sets empty again; complete sets when the shifter
  // goes idle with nothing waiting. Hardware set wins for empty; a buffer write wins for complete.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_q.tx_empty <= sirq_pkg::status_reset[sirq_pkg::st_tx_empty_bit];
      status_q.tx_done  <= sirq_pkg::status_reset[sirq_pkg::st_tx_done_bit];
    end else begin
      if (shift_load) begin
        status_q.tx_empty <= 1'b1;
      end else if (txbuf_write) begin
        status_q.tx_empty <= 1'b0;
      end
      if (~shift_busy & status_q.tx_empty & ~txbuf_write) begin
        status_q.tx_done <= 1'b1;
      end else if (txbuf_write | shift_load) begin
        status_q.tx_done <= 1'b0;
      end
    end
  end

  // Receive flags set on a completed byte; writing zero clears them,
  // and reading the receive buffer also clears the full flag.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_q.rx_full <= sirq_pkg::status_reset[sirq_pkg::st_rx_full_bit];
      status_q.overrun <= sirq_pkg::status_reset[sirq_pkg::st_overrun_bit];
      status_q.framing <= sirq_pkg::status_reset[sirq_pkg::st_framing_bit];
      status_q.parity  <= sirq_pkg::status_reset[sirq_pkg::st_parity_bit];
    end else begin
      if (rx_event) begin
        status_q.rx_full <= 1'b1;
      end else if (rxbuf_read | (status_write &
                   ~hwdata[sirq_pkg::st_rx_full_bit])) begin
        status_q.rx_full <= 1'b0;
      end
      if (rx_event & (rx_sync_q.overrun | status_q.rx_full)) begin
        status_q.overrun <= 1'b1;
      end else if (status_write & ~hwdata[sirq_pkg::st_overrun_bit]) begin
        status_q.overrun <= 1'b0;
      end
      if (rx_event & rx_sync_q.framing) begin
        status_q.framing <= 1'b1;
      end else if (status_write & ~hwdata[sirq_pkg::st_framing_bit]) begin
        status_q.framing <= 1'b0;
      end
      if (rx_event & rx_sync_q.parity) begin
        status_q.parity <= 1'b1;
      end else if (status_write & ~hwdata[sirq_pkg::st_parity_bit]) begin
        status_q.parity <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control_q <= sirq_pkg::control_reset;
      mask_q    <= sirq_pkg::mask_reset;
    end else begin
      if (wr_pend_q & is_access(addr_q, sirq_pkg::control_offset)) begin
        control_q <= hwdata[3:0];
      end
      if (wr_pend_q & is_access(addr_q, sirq_pkg::mask_offset)) begin
        mask_q <= hwdata[5:0];
      end
    end
  end

  // Sticky event bits latch the rising edge of each of the six causes.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_prev_q <= sirq_pkg::status_reset;
    end else begin
      status_prev_q <= status_q;
    end
  end

  assign evt_set = status_q & ~status_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_evt
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          evt_q[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_q[gi] <= 1'b1;
        end else if (evt_write & hwdata[gi]) begin
          evt_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Requests are plain levels of flag and enable, so an enable set while
  // a transmit flag still holds its reset value requests at once.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      requests <= '0;
      irq      <= 1'b0;
    end else begin
      requests.rx_full_request  <= status_q.rx_full
                                   & control_q[sirq_pkg::ct_rx_irq_bit];
      requests.tx_empty_request <= status_q.tx_empty
                                   & control_q[sirq_pkg::ct_tx_irq_bit];
      requests.tx_end_request   <= status_q.tx_done
                                   & control_q[sirq_pkg::ct_te_irq_bit];
      requests.rx_error_request <= (status_q.overrun | status_q.framing
                                   | status_q.parity)
                                   & control_q[sirq_pkg::ct_err_irq_bit];
      irq <= |(evt_q & mask_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      tx_busy <= shift_busy;
      tx_data <= shift_data;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (addr_q)
      sirq_pkg::status_offset:  rdata_d[5:0] = status_q;
      sirq_pkg::control_offset: rdata_d[3:0] = control_q;
      sirq_pkg::data_offset:    rdata_d[7:0] = txbuf_q;
      sirq_pkg::rxdata_offset:  rdata_d[7:0] = rxbuf_q;
      sirq_pkg::evt_offset:     rdata_d[5:0] = evt_q;
      sirq_pkg::mask_offset:    rdata_d[5:0] = mask_q;
      default:                  rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase so it stands in the
  // data phase straight from a flip-flop.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready & hsel & htrans[1] & ~hwrite) begin
      case (haddr[7:0])
        sirq_pkg::status_offset:  hrdata <= {26'h0, status_q};
        sirq_pkg::control_offset: hrdata <= {28'h0, control_q};
        sirq_pkg::data_offset:    hrdata <= {24'h0, txbuf_q};
        sirq_pkg::rxdata_offset:  hrdata <= {24'h0, rxbuf_q};
        sirq_pkg::evt_offset:     hrdata <= {26'h0, evt_q};
        sirq_pkg::mask_offset:    hrdata <= {26'h0, mask_q};
        default:                  hrdata <= 32'h0000_0000;
      endcase
    end else if (wr_pend_q) begin
      hrdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ### dv/sirq_monitor.sv
// Assertion checker for the serial port interrupt request block.
`default_nettype none
module sirq_monitor (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hwdata,
  input wire logic                   tx_busy,
  input wire sirq_pkg::sirq_req_type requests
);
  logic       wr_q;
  logic [7:0] ad_q;
  logic [3:0] en_q;
  logic       ctl_wr;
  logic       buf_wr;
  assign ctl_wr = wr_q && hready && ad_q == sirq_pkg::control_offset;
  assign buf_wr = wr_q && hready && ad_q == sirq_pkg::data_offset;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      ad_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel & htrans[1] & hwrite;
      ad_q <= haddr[7:0];
    end
  end
  // Shadow of the enables, taken at the end of the data phase like the slave.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en_q <= 4'h0;
    end else if (ctl_wr) begin
      en_q <= hwdata[3:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_launch;
    buf_wr && !tx_busy;
  endsequence
  sequence s_hold;
    tx_busy [*8];
  endsequence
  a_busy_span: assert property ($rose(tx_busy) |-> s_hold)
    else $error("transmit shifter released early");
  a_load_start: assert property (s_launch |-> ##[1:4] $rose(tx_busy))
    else $error("idle shifter did not take buffered byte");
  a_early_empty: assert property (ctl_wr && hwdata[1] && !tx_busy
    |-> ##[1:4] requests.tx_empty_request)
    else $error("early empty enable gave no request");
  a_early_end: assert property (ctl_wr && hwdata[2] && !tx_busy
    |-> ##[1:4] requests.tx_end_request)
    else $error("early end enable gave no request");
  a_rx_gate: assert property (
    requests.rx_full_request |-> $past(en_q[0]))
    else $error("receive request without enable");
  a_tx_gate: assert property (
    requests.tx_empty_request |-> $past(en_q[1]))
    else $error("empty request without enable");
  a_end_gate: assert property (
    requests.tx_end_request |-> $past(en_q[2]))
    else $error("end request without enable");
  a_err_gate: assert property (
    requests.rx_error_request |-> $past(en_q[3]))
    else $error("error request without enable");
  a_drop_off: assert property (
    ctl_wr && hwdata[3:0] == 4'h0 |-> ##2 requests == 4'h0)
    else $error("requests stayed after disable");
endmodule
`default_nettype wire

// ### dv/sirq_intc_model.sv
// Interrupt controller stand-in: remembers every request line it has seen.
`default_nettype none
module sirq_intc_model (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire sirq_pkg::sirq_req_type requests,
  output var logic [3:0]             pend_q
);
  // Level requests are latched so a short assertion is not lost.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_q <= 4'h0;
    end else begin
      pend_q <= pend_q | requests;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench for the serial port interrupt request block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        rx_valid = 1'b0, rx_overrun = 1'b0, rx_framing = 1'b0;
  logic        rx_parity = 1'b0, tx_busy, irq;
  logic [7:0]  rx_data = 8'h00, tx_data;
  logic [3:0]  pend_q;
  int          n_fail = 0, n_tests = 0;
  sirq_pkg::sirq_req_type requests;
  assign hready = hreadyout;
  always #4 clk_sys = ~clk_sys;
  sirq_top dut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_valid, .rx_data,
    .rx_overrun, .rx_framing, .rx_parity, .tx_busy, .tx_data, .requests,
    .irq);
  sirq_intc_model intc (.clk_sys, .rst_n, .requests, .pend_q);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rx_byte(input logic [7:0] d, input logic [2:0] e);
    @(posedge clk_sys);
    rx_data <= d;
    {rx_overrun, rx_framing, rx_parity} <= e;
    rx_valid <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rx_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    bus(1'b0, sirq_pkg::status_offset, 32'h0);
    chk(rd, 32'h06);
    bus(1'b0, sirq_pkg::control_offset, 32'h0);
    chk(rd, 32'h0);
    chk({28'h0, requests}, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_early;
    bus(1'b1, sirq_pkg::control_offset, 32'h6);
    step();
    chk({28'h0, requests}, 32'h6);
    bus(1'b1, sirq_pkg::control_offset, 32'h0);
    step();
    chk({28'h0, requests}, 32'h0);
    $display("test early enable done");
  endtask
  task automatic t_tx;
    bus(1'b1, sirq_pkg::data_offset, 32'h5a);
    bus(1'b1, sirq_pkg::control_offset, 32'h6);
    step();
    // The shifter has moved the byte two places, filling with idle ones.
    chk({23'h0, tx_busy, tx_data}, 32'h1d6);
    chk({28'h0, requests}, 32'h2);
    bus(1'b1, sirq_pkg::data_offset, 32'ha5);
    step();
    chk({28'h0, requests}, 32'h0);
    repeat (30) step();
    // Both bytes are out, so the line rests at its idle ones.
    chk({23'h0, tx_busy, tx_data}, 32'h0ff);
    chk({28'h0, requests}, 32'h6);
    bus(1'b1, sirq_pkg::control_offset, 32'h0);
    $display("test transmit done");
  endtask
  task automatic t_rx;
    bus(1'b1, sirq_pkg::control_offset, 32'h9);
    rx_byte(8'h3c, 3'b000);
    chk({28'h0, requests}, 32'h1);
    bus(1'b0, sirq_pkg::rxdata_offset, 32'h0);
    chk(rd, 32'h3c);
    step();
    chk({28'h0, requests}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rx_byte(8'h00, 3'(3'b001 << i));
      chk({31'h0, requests.rx_error_request}, 32'h1);
      bus(1'b1, sirq_pkg::status_offset, 32'h0);
      step();
      chk({28'h0, requests}, 32'h0);
    end
    $display("test receive done");
  endtask
  task automatic t_irq;
    bus(1'b1, sirq_pkg::evt_offset, 32'h3f);
    bus(1'b1, sirq_pkg::mask_offset, 32'h0);
    rx_byte(8'h11, 3'b000);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, sirq_pkg::mask_offset, 32'h1);
    step();
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, sirq_pkg::evt_offset, 32'h1);
    step();
    chk({31'h0, irq}, 32'h0);
    chk({28'h0, pend_q}, 32'hf);
    $display("test interrupt done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // The tests need well under a thousand cycles; this only catches a hang.
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_early();
    t_tx();
    t_rx();
    t_irq();
    tally_and_finish();
  end
endmodule
bind sirq_top sirq_monitor mon (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .tx_busy, .requests);
`default_nettype wire
